// File: hw/srw_router.sv
// web path router: hop byte routing, channel decode, cut-through forwarding, pair insertion
// How it works
// - single-port node accepts only hop byte zero, then decodes the channel.
// - single-port node rejects nonzero hop byte with bad-route error recovery.
// - single-port node reports link number one.
// - two-port node accepts zero, else decrements count and forwards out other port.
// - two-port node rejects flag-set zero-count byte with bad-route recovery.
// - two-port node reports link one or two for the port concerned.
// - switch has an even port count between 4 and 126.
// - switch accepts hop byte zero from any port and decodes the channel.
// - count within port count: send out that port and delete the hop byte.
// - count above port count: use paired port, subtract ports plus one, keep byte.
// - switch rejects 80h, clear flag within range, or count equal to input port.
// - switch ports are numbered from one for routing and reporting.
// - channels 0-127 use one byte, 128-16383 use two bytes.
// - first channel byte 80h or malformed channel gives bad-route recovery.
// - flow-control indications go out as two consecutive like symbols.
// - act on a pair only when both halves arrive back to back.
// - flow control is per link; pair symbols are never forwarded.
// - outgoing pairs may interleave into a frame and take priority.
// - inbound error after forwarding began sends frame-kill then delimiter.
// - regenerate frame check when forwarding; outcomes only after check passes.
// - channel zero is always there for service messages.
`timescale 1ns/1ps
module srw_router (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] node_kind_i,
    input wire logic [6:0] port_count_i,
    input wire logic [6:0] in_port_i,
    input wire logic rx_valid_i,
    input wire logic rx_special_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_err_i,
    input wire logic crc_ok_i,
    input wire logic send_ack_i,
    input wire logic send_buf_free_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic out_special_o,
    output logic [7:0] out_data_o,
    output logic pair_sent_o,
    output logic fwd_active_o,
    output logic [6:0] fwd_port_o,
    output logic frame_accept_o,
    output logic [13:0] chan_num_o,
    output logic service_message_o,
    output logic frame_reject_o,
    output logic link_error_recovery_o,
    output logic [3:0] fault_code_o,
    output logic [6:0] report_port_o,
    output logic config_bad_o,
    output logic ack_pair_o,
    output logic buf_free_pair_o,
    output logic pair_error_o
);

    typedef struct packed {
        srw_pkg::srw_state_t st;
        srw_pkg::srw_act_t act;
        logic [7:0][7:0] q;
        logic [3:0] q_cnt;
        logic [31:0] crc;
        logic [2:0] tail_idx;
        logic popped;
        logic kill;
        logic kill_ph;
        logic pend_ack;
        logic pend_bf;
        logic pair_sec;
        logic pair_sent;
        logic out_valid;
        logic out_special;
        logic [7:0] out_data;
        logic [6:0] chan_hi;
        logic [13:0] chan;
        logic svc;
        logic accept;
        logic reject;
        logic [3:0] fault;
        logic [6:0] rep_port;
        logic fwd_active;
        logic [6:0] fwd_port;
    } srw_rt_state_t;

    srw_rt_state_t s_r;
    srw_rt_state_t s_nxt;
    logic cfg_ok;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic srw_pkg::srw_route_t route_hop(input logic [1:0] kind,
            input logic [6:0] ports, input logic [6:0] inp, input logic ok,
            input logic [7:0] hop);
        srw_pkg::srw_route_t r;
        logic [6:0] idx;
        logic ext;
        idx = hop[6:0];
        ext = hop[srw_pkg::HOP_EXT_BIT];
        r.act = srw_pkg::ACT_REJECT;
        r.hop = hop;
        r.port = inp;
        r.del = 1'b0;
        if (hop == srw_pkg::HOP_LOCAL) begin
            r.act = srw_pkg::ACT_ACCEPT;
        end else if (kind == srw_pkg::NODE_DUAL && idx != 7'h00) begin
            r.act = srw_pkg::ACT_FWD;
            r.hop = {ext, idx - 7'h01};
            r.port = (inp == srw_pkg::PORT_ONE) ? srw_pkg::PORT_TWO : srw_pkg::PORT_ONE;
        end else if (kind == srw_pkg::NODE_SWITCH && ok) begin
            if (idx > ports) begin
                r.act = srw_pkg::ACT_FWD;
                r.hop = {ext, idx - ports - 7'h01};
                r.port = inp[0] ? inp + 7'h01 : inp - 7'h01;
            end else if (!(idx == inp || !ext || hop == srw_pkg::HOP_EXT_ONLY)) begin
                r.act = srw_pkg::ACT_FWD;
                r.del = 1'b1;
                r.port = idx;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (r[31] ^ d[i]) begin
                r = {r[30:0], 1'b0} ^ srw_pkg::CRC_POLY;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction

    // an out-of-range or odd switch port count rejects every non-local route
    assign cfg_ok = port_count_i >= srw_pkg::SW_PORTS_MIN
        && port_count_i <= srw_pkg::SW_PORTS_MAX && !port_count_i[0];

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        srw_pkg::srw_route_t rt;
        logic [31:0] crc_inv;
        logic is_flag;
        logic is_kill;
        logic fin;
        srw_pkg::srw_act_t fin_act;
        rt = route_hop(node_kind_i, port_count_i, in_port_i, cfg_ok, rx_data_i);
        crc_inv = ~s_r.crc;
        is_flag = rx_valid_i && rx_special_i && rx_data_i == srw_pkg::SYM_FLAG;
        is_kill = rx_err_i || (rx_valid_i && rx_special_i && rx_data_i == srw_pkg::SYM_ABORT);
        fin = 1'b0;
        fin_act = srw_pkg::ACT_REJECT;
        s_nxt = s_r;
        s_nxt.accept = 1'b0;
        s_nxt.reject = 1'b0;
        s_nxt.pair_sent = 1'b0;

        // outbound character slot
        if (out_ready_i) begin
            s_nxt.out_valid = 1'b0;
            s_nxt.out_special = 1'b0;
            s_nxt.out_data = 8'h00;
            if (s_r.pair_sec) begin
                s_nxt.out_valid = 1'b1;
                s_nxt.out_special = 1'b1;
                s_nxt.out_data = s_r.out_data;
                s_nxt.pair_sec = 1'b0;
                s_nxt.pair_sent = 1'b1;
            end else if (s_r.kill) begin
                s_nxt.out_valid = 1'b1;
                s_nxt.out_special = 1'b1;
                s_nxt.out_data = s_r.kill_ph ? srw_pkg::SYM_FLAG : srw_pkg::SYM_ABORT;
                s_nxt.kill_ph = !s_r.kill_ph;
                s_nxt.kill = !s_r.kill_ph;
            end else if (s_r.pend_ack || s_r.pend_bf) begin
                // the pair jumps ahead of queued frame characters
                s_nxt.out_valid = 1'b1;
                s_nxt.out_special = 1'b1;
                s_nxt.out_data = s_r.pend_ack ? srw_pkg::SYM_ACK : srw_pkg::SYM_BUF_FREE;
                s_nxt.pend_ack = 1'b0;
                s_nxt.pend_bf = s_r.pend_ack ? s_r.pend_bf : 1'b0;
                s_nxt.pair_sec = 1'b1;
            end else if ((s_r.st == srw_pkg::S_BODY || s_r.st == srw_pkg::S_TAIL)
                    && s_r.q_cnt > srw_pkg::CRC_LAG) begin
                // the last four held back may be the inbound check bytes
                s_nxt.out_valid = 1'b1;
                s_nxt.out_data = s_r.q[0];
                s_nxt.crc = crc_next(s_r.crc, s_r.q[0]);
                s_nxt.popped = 1'b1;
                for (int i = 0; i < srw_pkg::Q_DEPTH - 1; i++) begin
                    s_nxt.q[i] = s_r.q[i + 1];
                end
                s_nxt.q_cnt = s_r.q_cnt - 4'h1;
            end else if (s_r.st == srw_pkg::S_TAIL) begin
                s_nxt.out_valid = 1'b1;
                if (s_r.tail_idx < srw_pkg::CRC_BYTES) begin
                    s_nxt.out_data = crc_inv[5'd31 - {s_r.tail_idx[1:0], 3'b000} -: 8];
                    s_nxt.tail_idx = s_r.tail_idx + 3'h1;
                end else begin
                    s_nxt.out_special = 1'b1;
                    s_nxt.out_data = srw_pkg::SYM_FLAG;
                    s_nxt.st = srw_pkg::S_IDLE;
                    s_nxt.q_cnt = 4'h0;
                    s_nxt.fwd_active = 1'b0;
                end
            end
        end
        // a request in the same cycle as the send of the previous pair is kept
        s_nxt.pend_ack = s_nxt.pend_ack | send_ack_i;
        s_nxt.pend_bf = s_nxt.pend_bf | send_buf_free_i;

        // inbound frame parse; pair symbols are left to the pair detector
        if (is_kill && s_r.st != srw_pkg::S_IDLE && s_r.st != srw_pkg::S_TAIL) begin
            if (s_r.st == srw_pkg::S_BODY && s_r.popped) begin
                s_nxt.kill = 1'b1;
                s_nxt.kill_ph = 1'b0;
            end
            s_nxt.st = srw_pkg::S_DROP;
            s_nxt.act = srw_pkg::ACT_DROP;
            s_nxt.q_cnt = 4'h0;
            s_nxt.fwd_active = 1'b0;
        end else if (is_flag) begin
            unique case (s_r.st)
                srw_pkg::S_HOP, srw_pkg::S_CH1, srw_pkg::S_CH2: begin
                    fin = 1'b1;
                end
                srw_pkg::S_DROP: begin
                    fin = 1'b1;
                    fin_act = s_r.act;
                end
                srw_pkg::S_BODY: begin
                    s_nxt.st = srw_pkg::S_TAIL;
                    s_nxt.tail_idx = 3'h0;
                end
                srw_pkg::S_IDLE, srw_pkg::S_TAIL: begin
                end
            endcase
        end else if (rx_valid_i && !rx_special_i) begin
            unique case (s_r.st)
                srw_pkg::S_IDLE: begin
                    s_nxt.crc = srw_pkg::CRC_PRESET;
                    s_nxt.popped = 1'b0;
                    s_nxt.q[0] = rx_data_i;
                    s_nxt.q_cnt = 4'h1;
                    s_nxt.st = srw_pkg::S_HOP;
                end
                srw_pkg::S_HOP: begin
                    s_nxt.act = rt.act;
                    s_nxt.fwd_port = rt.port;
                    if (rt.act == srw_pkg::ACT_FWD) begin
                        s_nxt.fwd_active = 1'b1;
                        s_nxt.st = srw_pkg::S_BODY;
                        if (!rt.del) begin
                            s_nxt.q[s_nxt.q_cnt[2:0]] = rt.hop;
                            s_nxt.q_cnt = s_nxt.q_cnt + 4'h1;
                        end
                    end else begin
                        s_nxt.q_cnt = 4'h0;
                        s_nxt.st = (rt.act == srw_pkg::ACT_ACCEPT) ? srw_pkg::S_CH1
                            : srw_pkg::S_DROP;
                    end
                end
                srw_pkg::S_CH1: begin
                    s_nxt.st = srw_pkg::S_DROP;
                    s_nxt.chan = {7'h00, rx_data_i[6:0]};
                    s_nxt.chan_hi = rx_data_i[6:0];
                    if (rx_data_i == srw_pkg::CHAN_BAD_FIRST) begin
                        s_nxt.act = srw_pkg::ACT_REJECT;
                    end else if (rx_data_i[srw_pkg::CHAN_EXT_BIT]) begin
                        s_nxt.st = srw_pkg::S_CH2;
                    end
                end
                srw_pkg::S_CH2: begin
                    s_nxt.st = srw_pkg::S_DROP;
                    s_nxt.chan = {s_r.chan_hi, rx_data_i[6:0]};
                    if (rx_data_i[srw_pkg::CHAN_EXT_BIT]) begin
                        s_nxt.act = srw_pkg::ACT_REJECT;
                    end
                end
                srw_pkg::S_BODY: begin
                    if (s_nxt.q_cnt == srw_pkg::Q_FULL) begin
                        // a stalled outbound link overran the cut-through queue
                        s_nxt.kill = s_r.popped;
                        s_nxt.kill_ph = 1'b0;
                        s_nxt.st = srw_pkg::S_DROP;
                        s_nxt.act = srw_pkg::ACT_DROP;
                        s_nxt.q_cnt = 4'h0;
                        s_nxt.fwd_active = 1'b0;
                    end else begin
                        s_nxt.q[s_nxt.q_cnt[2:0]] = rx_data_i;
                        s_nxt.q_cnt = s_nxt.q_cnt + 4'h1;
                    end
                end
                srw_pkg::S_DROP, srw_pkg::S_TAIL: begin
                end
            endcase
        end

        // outcomes are released only for a frame whose check passed
        if (fin) begin
            s_nxt.st = srw_pkg::S_IDLE;
            s_nxt.q_cnt = 4'h0;
            if (crc_ok_i && fin_act != srw_pkg::ACT_DROP) begin
                s_nxt.rep_port = (node_kind_i == srw_pkg::NODE_SINGLE) ? srw_pkg::PORT_ONE
                    : in_port_i;
                if (fin_act == srw_pkg::ACT_ACCEPT) begin
                    s_nxt.accept = 1'b1;
                    s_nxt.svc = (s_r.chan == srw_pkg::CHAN_SERVICE);
                end else begin
                    s_nxt.reject = 1'b1;
                    s_nxt.fault = srw_pkg::FAULT_BAD_ROUTE;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
            s_r.st <= srw_pkg::S_IDLE;
            s_r.crc <= srw_pkg::CRC_PRESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    srw_pair_det u_pair_det (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .rx_valid_i(rx_valid_i),
        .rx_special_i(rx_special_i),
        .rx_data_i(rx_data_i),
        .ack_pair_o(ack_pair_o),
        .buf_free_pair_o(buf_free_pair_o),
        .pair_error_o(pair_error_o)
    );

    assign out_valid_o = s_r.out_valid;
    assign out_special_o = s_r.out_special;
    assign out_data_o = s_r.out_data;
    assign pair_sent_o = s_r.pair_sent;
    assign fwd_active_o = s_r.fwd_active;
    assign fwd_port_o = s_r.fwd_port;
    assign frame_accept_o = s_r.accept;
    assign chan_num_o = s_r.chan;
    assign service_message_o = s_r.svc;
    assign frame_reject_o = s_r.reject;
    assign link_error_recovery_o = s_r.reject;
    assign fault_code_o = s_r.fault;
    assign report_port_o = s_r.rep_port;
    assign config_bad_o = (node_kind_i == srw_pkg::NODE_SWITCH) && !cfg_ok;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_reject_recovery: assert property (
        frame_reject_o |-> link_error_recovery_o && fault_code_o == srw_pkg::FAULT_BAD_ROUTE
            && !frame_accept_o
    ) else $error("reject without bad-route recovery");

    a_single_port_one: assert property (
        (frame_accept_o || frame_reject_o) && node_kind_i == srw_pkg::NODE_SINGLE
        |-> report_port_o == srw_pkg::PORT_ONE
    ) else $error("single-port node reported a port other than one");

    a_kill_then_flag: assert property (
        out_valid_o && out_special_o && out_data_o == srw_pkg::SYM_ABORT && out_ready_i
        |=> out_valid_o && out_special_o && out_data_o == srw_pkg::SYM_FLAG
    ) else $error("frame kill not followed by delimiter");

    a_pair_back_to_back: assert property (
        s_r.pair_sec && out_ready_i
        |=> out_valid_o && out_special_o && out_data_o == $past(out_data_o) && pair_sent_o
    ) else $error("flow-control pair split");

    a_service_chan: assert property (
        frame_accept_o |-> service_message_o == (chan_num_o == srw_pkg::CHAN_SERVICE)
    ) else $error("service channel flag wrong");

    a_check_gates: assert property (
        (frame_accept_o || frame_reject_o) |-> $past(crc_ok_i && rx_valid_i && rx_special_i)
    ) else $error("outcome released without a passed frame check");

    a_dual_other_port: assert property (
        $rose(fwd_active_o) && node_kind_i == srw_pkg::NODE_DUAL
        |-> fwd_port_o != $past(in_port_i) && $past(rx_data_i) != srw_pkg::HOP_LOCAL
    ) else $error("dual-port forward to same port or on local hop");

    a_switch_out_port: assert property (
        $rose(fwd_active_o) && node_kind_i == srw_pkg::NODE_SWITCH
        |-> fwd_port_o != $past(in_port_i) && fwd_port_o != 7'h00
            && fwd_port_o <= port_count_i
    ) else $error("switch forward port illegal");

endmodule

// File: pkg/srw_pkg.sv
// constants and types shared by the web path router and its flow-control pair detector
package srw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // node kinds and link characters
    localparam logic [1:0] NODE_SINGLE = 2'h0;
    localparam logic [1:0] NODE_DUAL = 2'h1;
    localparam logic [1:0] NODE_SWITCH = 2'h2;

    // special character codes, valid only while the special flag is high
    localparam logic [7:0] SYM_FLAG = 8'h01;
    localparam logic [7:0] SYM_ACK = 8'h02;
    localparam logic [7:0] SYM_BUF_FREE = 8'h03;
    localparam logic [7:0] SYM_ABORT = 8'h04;

    ////////////////////////////////////////////////////////////////////////////////
    // hop byte and channel fields
    localparam int HOP_EXT_BIT = 7;
    localparam logic [7:0] HOP_LOCAL = 8'h00;
    localparam logic [7:0] HOP_EXT_ONLY = 8'h80;
    localparam logic [7:0] CHAN_BAD_FIRST = 8'h80;
    localparam int CHAN_EXT_BIT = 7;
    localparam logic [13:0] CHAN_SERVICE = 14'h0000;

    localparam logic [6:0] PORT_ONE = 7'h01;
    localparam logic [6:0] PORT_TWO = 7'h02;
    localparam logic [6:0] SW_PORTS_MIN = 7'h04;
    localparam logic [6:0] SW_PORTS_MAX = 7'h7e;

    localparam logic [3:0] FAULT_NONE = 4'h0;
    localparam logic [3:0] FAULT_BAD_ROUTE = 4'h9;

    ////////////////////////////////////////////////////////////////////////////////
    // frame check and cut-through queue
    localparam logic [31:0] CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC_PRESET = 32'hffffffff;
    localparam int Q_DEPTH = 8;
    localparam logic [3:0] Q_FULL = 4'h8;
    localparam logic [3:0] CRC_LAG = 4'h4;
    localparam logic [2:0] CRC_BYTES = 3'h4;

    typedef enum logic [1:0] {
        ACT_ACCEPT = 2'h0,
        ACT_FWD = 2'h1,
        ACT_REJECT = 2'h2,
        ACT_DROP = 2'h3
    } srw_act_t;

    typedef struct packed {
        srw_act_t act;
        logic [7:0] hop;
        logic [6:0] port;
        logic del;
    } srw_route_t;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_HOP = 7'h02,
        S_CH1 = 7'h04,
        S_CH2 = 7'h08,
        S_BODY = 7'h10,
        S_DROP = 7'h20,
        S_TAIL = 7'h40
    } srw_state_t;

    typedef enum logic [1:0] {
        PK_NONE = 2'h0,
        PK_ACK = 2'h1,
        PK_BF = 2'h2
    } srw_pair_t;

endpackage

// File: hw/srw_pair_det.sv
// receive-side detector for acknowledge and buffer-free character pairs
`timescale 1ns/1ps
module srw_pair_det (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic rx_valid_i,
    input wire logic rx_special_i,
    input wire logic [7:0] rx_data_i,
    output logic ack_pair_o,
    output logic buf_free_pair_o,
    output logic pair_error_o
);

    typedef struct packed {
        srw_pkg::srw_pair_t held;
        logic ack;
        logic bf;
        logic err;
    } srw_pd_state_t;

    srw_pd_state_t s_r;
    srw_pd_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        srw_pkg::srw_pair_t kind;
        kind = srw_pkg::PK_NONE;
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.bf = 1'b0;
        s_nxt.err = 1'b0;
        if (rx_valid_i) begin
            if (rx_special_i && rx_data_i == srw_pkg::SYM_ACK) begin
                kind = srw_pkg::PK_ACK;
            end else if (rx_special_i && rx_data_i == srw_pkg::SYM_BUF_FREE) begin
                kind = srw_pkg::PK_BF;
            end
            // any other character between the two halves breaks the pair
            if (kind != srw_pkg::PK_NONE && kind == s_r.held) begin
                s_nxt.ack = (kind == srw_pkg::PK_ACK);
                s_nxt.bf = (kind == srw_pkg::PK_BF);
                s_nxt.held = srw_pkg::PK_NONE;
            end else begin
                s_nxt.err = (s_r.held != srw_pkg::PK_NONE);
                s_nxt.held = kind;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ack_pair_o = s_r.ack;
    assign buf_free_pair_o = s_r.bf;
    assign pair_error_o = s_r.err;

    ////////////////////////////////////////////////////////////////////////////////
    a_pair_second_half: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ack_pair_o |-> $past(rx_valid_i && rx_special_i && rx_data_i == srw_pkg::SYM_ACK)
    ) else $error("ack pair reported without a closing ack character");

    a_lone_half_error: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (s_r.held == srw_pkg::PK_ACK && rx_valid_i
            && !(rx_special_i && rx_data_i == srw_pkg::SYM_ACK))
        |=> pair_error_o && !ack_pair_o
    ) else $error("broken ack pair not flagged");

endmodule

// File: tb/srw_link_peer.sv
// neighbouring port model: offers outbound slots and counts received ack pairs
`timescale 1ns/1ps
module srw_link_peer (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic out_valid_i,
    input wire logic out_special_i,
    input wire logic [7:0] out_data_i,
    output logic out_ready_o,
    output logic [7:0] ack_pairs_o
);
    logic half_r;
    logic is_ack;
    assign is_ack = out_valid_i && out_special_i && out_data_i == srw_pkg::SYM_ACK;
    // slow mode offers a slot every other cycle, as a slower link would
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_ready_o <= 1'b0;
            half_r <= 1'b0;
            ack_pairs_o <= 8'h00;
        end else begin
            out_ready_o <= slow_i ? !out_ready_o : 1'b1;
            if (out_ready_o) begin
                half_r <= is_ack && !half_r;
                if (is_ack && half_r) ack_pairs_o <= ack_pairs_o + 8'h01;
            end
        end
    end
endmodule

// File: tb/test_srw_router.sv
// self-checking bench for the web path router
`timescale 1ns/1ps
module test_srw_router;
    logic sys_clk_i = 0, rst_n_i = 0, rx_valid_i = 0, rx_special_i = 0, rx_err_i = 0;
    logic crc_ok_i = 1, send_ack_i = 0, send_buf_free_i = 0, slow = 0, out_ready_i;
    logic [1:0] node_kind_i = 0;
    logic [6:0] port_count_i = 7'h08, in_port_i = 7'h01, fwd_port_o, report_port_o, fport;
    logic [7:0] rx_data_i = 0, out_data_o, acks, hop_out;
    logic [13:0] chan_num_o;
    logic [3:0] fault_code_o;
    logic out_valid_o, out_special_o, pair_sent_o, fwd_active_o, frame_accept_o, service_message_o;
    logic frame_reject_o, link_error_recovery_o, config_bad_o, ack_pair_o, buf_free_pair_o;
    logic pair_error_o, acc, rej, ap, pe;
    int num_errors = 0, comparisons = 0, n_out;
    initial forever #2.5 sys_clk_i = !sys_clk_i;
    srw_router u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .node_kind_i(node_kind_i),
        .port_count_i(port_count_i), .in_port_i(in_port_i), .rx_valid_i(rx_valid_i),
        .rx_special_i(rx_special_i), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i),
        .crc_ok_i(crc_ok_i), .send_ack_i(send_ack_i), .send_buf_free_i(send_buf_free_i),
        .out_ready_i(out_ready_i), .out_valid_o(out_valid_o), .out_special_o(out_special_o),
        .out_data_o(out_data_o), .pair_sent_o(pair_sent_o), .fwd_active_o(fwd_active_o),
        .fwd_port_o(fwd_port_o), .frame_accept_o(frame_accept_o), .chan_num_o(chan_num_o),
        .service_message_o(service_message_o), .frame_reject_o(frame_reject_o),
        .link_error_recovery_o(link_error_recovery_o), .fault_code_o(fault_code_o),
        .report_port_o(report_port_o), .config_bad_o(config_bad_o), .ack_pair_o(ack_pair_o),
        .buf_free_pair_o(buf_free_pair_o), .pair_error_o(pair_error_o));
    srw_link_peer u_peer (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
        .out_valid_i(out_valid_o), .out_special_i(out_special_o), .out_data_i(out_data_o),
        .out_ready_o(out_ready_i), .ack_pairs_o(acks));
    // sticky copies of one-cycle pulses, cleared by each scenario
    always @(posedge sys_clk_i) begin
        if (frame_accept_o === 1'b1) acc = 1;
        if (frame_reject_o === 1'b1 && link_error_recovery_o === 1'b1) rej = 1;
        if (fwd_active_o === 1'b1) fport = fwd_port_o;
        if (ack_pair_o === 1'b1) ap = 1;
        if (pair_error_o === 1'b1) pe = 1;
        if (out_valid_o === 1'b1 && out_ready_i && !out_special_o) begin
            n_out++;
            if (n_out == 2) hop_out = out_data_o;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic put(input logic sp, input logic [7:0] d);
        @(posedge sys_clk_i);
        rx_valid_i <= 1;
        rx_special_i <= sp;
        rx_data_i <= d;
    endtask
    // control, hop and channel bytes, four stand-in check bytes, then the closing flag
    task automatic frame(input logic [1:0] k, input logic [6:0] p, input logic [7:0] h, c);
        acc = 0; rej = 0; fport = 0; n_out = 0;
        @(posedge sys_clk_i);
        node_kind_i <= k;
        in_port_i <= p;
        put(0, 8'h11); put(0, h); put(0, c);
        repeat (4) put(0, 8'h42); put(1, srw_pkg::SYM_FLAG);
        @(posedge sys_clk_i);
        rx_valid_i <= 0;
        repeat (16) @(posedge sys_clk_i);
    endtask
    task automatic t_local();
        frame(srw_pkg::NODE_SINGLE, 1, 8'h00, 8'h05);
        check(acc, 1); check(chan_num_o, 5); check(report_port_o, 1);
        frame(srw_pkg::NODE_SINGLE, 1, 8'h01, 8'h05);
        check(rej, 1); check(fault_code_o, 9);
        frame(srw_pkg::NODE_SINGLE, 1, 8'h00, 8'h81);
        check(acc, 1); check(chan_num_o, 14'h00c2);
        frame(srw_pkg::NODE_SINGLE, 1, 8'h00, 8'h80);
        check(rej, 1);
        $display("local routing done");
    endtask
    task automatic t_dual();
        frame(srw_pkg::NODE_DUAL, 1, 8'h03, 8'h05);
        check(fport, 2); check(rej, 0); check(hop_out, 2);
        frame(srw_pkg::NODE_DUAL, 2, 8'h80, 8'h05);
        check(rej, 1); check(report_port_o, 2);
        $display("dual routing done");
    endtask
    task automatic t_switch();
        frame(srw_pkg::NODE_SWITCH, 1, 8'h85, 8'h05);
        check(fport, 5); check(hop_out, 5);
        frame(srw_pkg::NODE_SWITCH, 3, 8'h0a, 8'h05);
        check(fport, 4); check(hop_out, 1);
        frame(srw_pkg::NODE_SWITCH, 3, 8'h83, 8'h05);
        check(rej, 1);
        frame(srw_pkg::NODE_SWITCH, 1, 8'h03, 8'h05);
        check(rej, 1);
        frame(srw_pkg::NODE_SWITCH, 4, 8'h00, 8'h00);
        check(acc, 1); check(report_port_o, 4); check(service_message_o, 1);
        port_count_i <= 7'h05;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i) check(config_bad_o, 1);
        port_count_i <= 7'h08;
        $display("switch routing done");
    endtask
    task automatic t_pairs();
        ap = 0; pe = 0;
        put(1, srw_pkg::SYM_ACK); put(0, 8'h33); put(1, srw_pkg::SYM_ACK);
        put(1, srw_pkg::SYM_BUF_FREE);
        @(posedge sys_clk_i) rx_valid_i <= 0;
        repeat (4) @(posedge sys_clk_i);
        check(ap, 0); check(pe, 1);
        put(1, srw_pkg::SYM_ACK); put(1, srw_pkg::SYM_ACK);
        @(posedge sys_clk_i) rx_valid_i <= 0;
        repeat (4) @(posedge sys_clk_i);
        check(ap, 1); check(acks, 0);
        slow <= 1;
        @(posedge sys_clk_i) send_ack_i <= 1;
        @(posedge sys_clk_i) send_ack_i <= 0;
        for (int i = 0; i < 20 && acks != 8'h01; i++) @(posedge sys_clk_i);
        check(acks, 1);
        $display("flow control pairs done");
    endtask
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1;
        t_local();
        t_dual();
        t_switch();
        t_pairs();
        complete_run();
    end
endmodule
